// >>> include/sasl_pkg.sv
`default_nettype none
package sasl_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [7:0] SYS_CTRL_OFS = 8'h80;
  localparam logic [7:0] MF_ROUTE_OFS = 8'h8C;
  localparam logic [7:0] FUNC_PM_OFS = 8'hA0;
  localparam logic [7:0] AUX_STAT_OFS = 8'hA4;

  // reset values
  localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MF_ROUTE_RST = 32'h0000_0000;
  localparam logic [5:0] FUNC_PM_RST = 6'h00;

  // system control fields
  localparam int unsigned OSC_EN_BIT = 27;

  // multifunction routing fields: 3-bit code per terminal, 4-bit stride
  localparam int unsigned MF_NUM = 8;
  localparam int unsigned MF_FLD_W = 3;
  localparam int unsigned MF_FLD_STRIDE = 4;
  localparam logic [2:0] MF_CODE_SLEEP = 3'h4;
  localparam logic [2:0] MF_CODE_LED0 = 3'h5;
  localparam logic [2:0] MF_CODE_LED1 = 3'h6;
  // terminals 7, 6, 2 and 1 may carry the sleep status
  localparam logic [7:0] MF_SLEEP_OK = 8'hC6;

  // function power management fields
  localparam int unsigned FUNC_PM_W = 6;
  localparam int unsigned PM_F0_LSB = 0;
  localparam int unsigned PM_F1_LSB = 2;
  localparam int unsigned PM_W = 2;
  localparam int unsigned PME0_BIT = 4;
  localparam int unsigned PME1_BIT = 5;
  localparam logic [1:0] PM_STATE_D3 = 2'h3;

  // status register bits
  localparam int unsigned STAT_SLEEP_BIT = 0;
  localparam int unsigned STAT_LED0_BIT = 1;
  localparam int unsigned STAT_LED1_BIT = 2;
  localparam int unsigned STAT_OSC_EN_BIT = 3;
  localparam int unsigned STAT_OSC_LVL_BIT = 4;
  localparam int unsigned STAT_CARD_SPEAKER_IN_BIT = 5;

  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OSC_HZ = 16_000;
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int unsigned LED_HOLD_MS = 64;
  localparam int unsigned LED_HOLD_CYC = (CLK_HZ / 1000) * LED_HOLD_MS;

  localparam int unsigned SOCK_NUM = 2;

  typedef enum logic {
    SASL_LED_IDLE,
    SASL_LED_HOLD
  } sasl_led_e;

  // per-socket card signals
  typedef struct packed {
    logic [1:0] card_is_cb;
    logic [1:0] card_io16;
    logic [1:0] battery_detect_two;
  } sasl_sock_s;

endpackage
`default_nettype wire

// >>> hw/sasl_ring_osc.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_ring_osc
  import sasl_pkg::*;
#(
  parameter int unsigned HALF_CYC = OSC_HALF_CYC,
  parameter int unsigned CNT_W = $clog2(HALF_CYC + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic en_i,
  // oscillator level
  output logic osc_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic level;
  } sasl_osc_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

  sasl_osc_s st_ff;
  sasl_osc_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!en_i) begin
      // parked low so the pin shows a clean level when stopped
      nxt_st.cnt = '0;
      nxt_st.level = 1'b0;
    end else if (st_ff.cnt == LAST) begin
      nxt_st.cnt = '0;
      nxt_st.level = ~st_ff.level;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign osc_o = st_ff.level;

endmodule
`default_nettype wire

// >>> hw/sasl_led_hold.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_led_hold
  import sasl_pkg::*;
#(
  parameter int unsigned HOLD_CYC = LED_HOLD_CYC,
  parameter int unsigned CNT_W = $clog2(HOLD_CYC + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // events
  input wire logic access_i,
  input wire logic cutoff_i,
  // indicator
  output logic led_o
);

  typedef struct packed {
    sasl_led_e state;
    logic [CNT_W-1:0] cnt;
    logic led;
  } sasl_hold_s;

  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(HOLD_CYC - 1);

  sasl_hold_s st_ff;
  sasl_hold_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      SASL_LED_IDLE: begin
        if (access_i) begin
          nxt_st.state = SASL_LED_HOLD;
          nxt_st.cnt = RELOAD;
        end
      end
      SASL_LED_HOLD: begin
        if (access_i) begin
          nxt_st.cnt = RELOAD;
        end else if (st_ff.cnt == '0) begin
          nxt_st.state = SASL_LED_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      default: begin
        nxt_st.state = SASL_LED_IDLE;
        nxt_st.cnt = '0;
      end
    endcase
    if (cutoff_i) begin
      nxt_st.state = SASL_LED_IDLE;
      nxt_st.cnt = '0;
    end
    nxt_st.led = (nxt_st.state == SASL_LED_HOLD);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '{state: SASL_LED_IDLE, cnt: '0, led: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign led_o = st_ff.led;

endmodule
`default_nettype wire

// >>> hw/sasl_top.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_top
  import sasl_pkg::*;
#(
  parameter int unsigned LED_HOLD_CYCLES = LED_HOLD_CYC,
  parameter int unsigned OSC_HALF_CYCLES = OSC_HALF_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // socket side
  input wire sasl_sock_s SOCK_I,
  input wire logic [SOCK_NUM-1:0] SOCK_ACCESS_I,
  // power management events
  input wire logic SUSPEND_I,
  input wire logic CLKRUN_STOP_I,
  // power switch clock pin
  input wire logic CLK_PIN_I,
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE_O,
  output logic SOCK_TIMING_CLK_O,
  // board outputs
  output logic SPEAKER_OUT_O,
  output logic [MF_NUM-1:0] MULTIFUNCTION_PIN_O,
  output logic [MF_NUM-1:0] MULTIFUNCTION_PIN_OE_O
);

  typedef struct packed {
    logic [DATA_W-1:0] sys_ctrl;
    logic [DATA_W-1:0] mf_route;
    logic [FUNC_PM_W-1:0] func_pm;
    logic [DATA_W-1:0] rdata;
    logic sleep_status_n;
    logic speaker_out;
    logic [MF_NUM-1:0] mf_out;
    logic [MF_NUM-1:0] mf_oe;
    logic clk_pin_out;
    logic clk_pin_oe;
    logic timing_clk;
  } sasl_top_s;

  localparam sasl_top_s TOP_RST = '{
    sys_ctrl: SYS_CTRL_RST,
    mf_route: MF_ROUTE_RST,
    func_pm: FUNC_PM_RST,
    rdata: '0,
    sleep_status_n: 1'b1,
    speaker_out: 1'b0,
    mf_out: '0,
    mf_oe: '0,
    clk_pin_out: 1'b0,
    clk_pin_oe: 1'b0,
    timing_clk: 1'b0
  };

  sasl_top_s st_ff;
  sasl_top_s nxt_st;

  logic osc_en;
  logic osc_level;
  logic led_cutoff;
  logic [SOCK_NUM-1:0] led_q;
  logic [SOCK_NUM-1:0] card_audio;
  logic both_d3;
  logic wake_en;
  logic [MF_FLD_W-1:0] mf_code [MF_NUM];
  logic [DATA_W-1:0] status_word;

  assign osc_en = st_ff.sys_ctrl[OSC_EN_BIT];

  sasl_ring_osc #(
    .HALF_CYC(OSC_HALF_CYCLES)
  ) u_ring_osc (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .en_i(osc_en),
    .osc_o(osc_level)
  );

  assign led_cutoff = SUSPEND_I | CLKRUN_STOP_I;

  // hold counters on the bus clock
  for (genvar s = 0; s < SOCK_NUM; s++) begin : g_led
    sasl_led_hold #(
      .HOLD_CYC(LED_HOLD_CYCLES)
    ) u_led_hold (
      .clk_i(CLOCK_I),
      .rst_n_i(NRST_I),
      .access_i(SOCK_ACCESS_I[s]),
      .cutoff_i(led_cutoff),
      .led_o(led_q[s])
    );
    assign card_audio[s] = SOCK_I.battery_detect_two[s] & (SOCK_I.card_io16[s] | SOCK_I.card_is_cb[s]);
  end

  for (genvar m = 0; m < MF_NUM; m++) begin : g_mf_code
    assign mf_code[m] = st_ff.mf_route[m*MF_FLD_STRIDE +: MF_FLD_W];
  end

  assign both_d3 = (st_ff.func_pm[PM_F0_LSB +: PM_W] == PM_STATE_D3)
                 & (st_ff.func_pm[PM_F1_LSB +: PM_W] == PM_STATE_D3);
  assign wake_en = st_ff.func_pm[PME0_BIT] | st_ff.func_pm[PME1_BIT];

  always_comb begin
    status_word = '0;
    status_word[STAT_SLEEP_BIT] = ~st_ff.sleep_status_n;
    status_word[STAT_LED0_BIT] = led_q[0];
    status_word[STAT_LED1_BIT] = led_q[1];
    status_word[STAT_OSC_EN_BIT] = osc_en;
    status_word[STAT_OSC_LVL_BIT] = osc_level;
    status_word[STAT_CARD_SPEAKER_IN_BIT] = st_ff.speaker_out;
  end

  always_comb begin
    nxt_st = st_ff;

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        SYS_CTRL_OFS: begin
          nxt_st.sys_ctrl = WDATA_I;
        end
        MF_ROUTE_OFS: begin
          nxt_st.mf_route = WDATA_I;
        end
        FUNC_PM_OFS: begin
          nxt_st.func_pm = WDATA_I[FUNC_PM_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // read data stand for one cycle only; unmapped reads give zero
    nxt_st.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        SYS_CTRL_OFS: begin
          nxt_st.rdata = st_ff.sys_ctrl;
        end
        MF_ROUTE_OFS: begin
          nxt_st.rdata = st_ff.mf_route;
        end
        FUNC_PM_OFS: begin
          nxt_st.rdata = {{(DATA_W-FUNC_PM_W){1'b0}}, st_ff.func_pm};
        end
        AUX_STAT_OFS: begin
          nxt_st.rdata = status_word;
        end
        default: begin
          nxt_st.rdata = '0;
        end
      endcase
    end

    nxt_st.sleep_status_n = ~(both_d3 & wake_en);

    nxt_st.speaker_out = ^card_audio;

    // pin direction follows the enable; oscillator drives it only as output
    nxt_st.clk_pin_oe = osc_en;
    nxt_st.clk_pin_out = osc_en & osc_level;
    // timing source divided from the bus clock, not the external clock, when enabled
    nxt_st.timing_clk = osc_en ? osc_level : CLK_PIN_I;

    for (int m = 0; m < MF_NUM; m++) begin
      nxt_st.mf_out[m] = 1'b0;
      nxt_st.mf_oe[m] = 1'b0;
      if ((mf_code[m] == MF_CODE_SLEEP) && MF_SLEEP_OK[m]) begin
        nxt_st.mf_oe[m] = 1'b1;
        nxt_st.mf_out[m] = nxt_st.sleep_status_n;
      end
      if (mf_code[m] == MF_CODE_LED0) begin
        nxt_st.mf_oe[m] = 1'b1;
        nxt_st.mf_out[m] = led_q[0];
      end
      if (mf_code[m] == MF_CODE_LED1) begin
        nxt_st.mf_oe[m] = 1'b1;
        nxt_st.mf_out[m] = led_q[1];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA_O = st_ff.rdata;
  assign CLK_PIN_O = st_ff.clk_pin_out;
  assign CLK_PIN_OE_O = st_ff.clk_pin_oe;
  assign SOCK_TIMING_CLK_O = st_ff.timing_clk;
  assign SPEAKER_OUT_O = st_ff.speaker_out;
  assign MULTIFUNCTION_PIN_O = st_ff.mf_out;
  assign MULTIFUNCTION_PIN_OE_O = st_ff.mf_oe;

endmodule
`default_nettype wire

// >>> testbench/sasl_sock_model.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_sock_model
  import sasl_pkg::*;
(
  // clock
  input wire logic clk_i,
  // bench commands
  input wire logic [5:0] cfg_i,
  input wire logic [SOCK_NUM-1:0] acc_i,
  // device clock pin
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  // socket and pin levels
  output sasl_sock_s sock_o,
  output logic [SOCK_NUM-1:0] access_o,
  output logic pin_o
);
  logic [1:0] div_ff = 2'h0;
  logic ext_ff = 1'h0;
  // free running board clock, slower than the bus clock
  always_ff @(posedge clk_i) begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3) begin
      ext_ff <= !ext_ff;
    end
  end
  assign sock_o = sasl_sock_s'(cfg_i);
  assign access_o = acc_i;
  // external clock only while the pin is an input
  assign pin_o = pin_oe_i ? pin_o_i : ext_ff;
endmodule
`default_nettype wire

// >>> testbench/sasl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_monitor
  import sasl_pkg::*;
#(
  parameter int unsigned LED_HOLD_CYCLES = LED_HOLD_CYC,
  parameter int unsigned OSC_HALF_CYCLES = OSC_HALF_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // socket and pins
  input wire sasl_sock_s SOCK_I,
  input wire logic [SOCK_NUM-1:0] SOCK_ACCESS_I,
  input wire logic SUSPEND_I,
  input wire logic CLKRUN_STOP_I,
  input wire logic CLK_PIN_I,
  input wire logic CLK_PIN_O,
  input wire logic CLK_PIN_OE_O,
  input wire logic SOCK_TIMING_CLK_O,
  input wire logic SPEAKER_OUT_O
);
  logic [1:0] up_ff;
  logic en_ff;
  logic pv_ff;
  logic [15:0] st_ff;
  logic cut;
  logic st_rd;
  assign cut = SUSPEND_I | CLKRUN_STOP_I;
  assign st_rd = RD_I && ADDR_I == AUX_STAT_OFS;
  // up_ff keeps $past away from values captured during reset
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      up_ff <= 2'h0;
      en_ff <= 1'h0;
      pv_ff <= 1'h0;
      st_ff <= 16'h0;
    end else begin
      up_ff <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
      en_ff <= (WR_I && ADDR_I == SYS_CTRL_OFS) ? WDATA_I[OSC_EN_BIT] : en_ff;
      pv_ff <= CLK_PIN_O;
      st_ff <= (!CLK_PIN_OE_O || CLK_PIN_O != pv_ff) ? 16'h0 : st_ff + 16'h1;
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  AST_CARD_SPEAKER_IN: assert property (up_ff == 2'h3 |-> SPEAKER_OUT_O ==
    $past(^(SOCK_I.battery_detect_two & (SOCK_I.card_io16 | SOCK_I.card_is_cb))))
    else $error("speaker output is not the socket audio xor");
  AST_PIN_DIR: assert property (up_ff == 2'h3 |-> CLK_PIN_OE_O == $past(en_ff))
    else $error("clock pin direction does not follow the control bit");
  AST_PIN_IDLE: assert property (!CLK_PIN_OE_O && $past(!CLK_PIN_OE_O) |-> !CLK_PIN_O)
    else $error("clock pin output active while oscillator is off");
  AST_OSC_RUN: assert property (st_ff <= OSC_HALF_CYCLES + 2)
    else $error("oscillator level stuck while enabled");
  AST_TCLK_EXT: assert property (up_ff == 2'h3 && !$past(en_ff) |->
    SOCK_TIMING_CLK_O == $past(CLK_PIN_I))
    else $error("timing clock does not follow the external pin");
  AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == '0)
    else $error("read data present without a read");
  AST_LED_CUT: assert property (st_rd && cut && $past(cut) |=>
    RDATA_O[STAT_LED1_BIT:STAT_LED0_BIT] == 2'h0)
    else $error("activity indicator on during cut off");
  AST_LED_ON: assert property (SOCK_ACCESS_I[1] && !cut ##1 !cut ##1 st_rd && !cut |=>
    RDATA_O[STAT_LED1_BIT])
    else $error("socket one access did not light its indicator");
  COV_ACCESS: cover property (SOCK_ACCESS_I != 2'h0);
  COV_OSC: cover property ($rose(CLK_PIN_OE_O));
  COV_STOP: cover property (CLKRUN_STOP_I);
endmodule
bind sasl_top sasl_monitor #(
  .LED_HOLD_CYCLES(LED_HOLD_CYCLES),
  .OSC_HALF_CYCLES(OSC_HALF_CYCLES)
) mon (.CLOCK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .SOCK_I,
  .SOCK_ACCESS_I, .SUSPEND_I, .CLKRUN_STOP_I, .CLK_PIN_I, .CLK_PIN_O, .CLK_PIN_OE_O,
  .SOCK_TIMING_CLK_O, .SPEAKER_OUT_O);
`default_nettype wire

// >>> testbench/sasl_test.sv
`timescale 1ns/100ps
`default_nettype none
module sasl_test;
  import sasl_pkg::*;
  localparam int HOLD = 20;
  localparam int HALF = 4;
  logic clk, nrst, wr, rd, susp, stop, pin_i, pin_o, pin_oe, tclk, spk, e, prev;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] acc, sacc;
  logic [5:0] cfg;
  logic [MF_NUM-1:0] mf, mf_oe;
  sasl_sock_s sock;
  logic [5:0] pmv [5] = '{6'h0F, 6'h1F, 6'h2F, 6'h3B, 6'h3E};
  int errors = 0;
  int checks_done = 0;
  int hi [2];
  int n;
  sasl_top #(.LED_HOLD_CYCLES(HOLD), .OSC_HALF_CYCLES(HALF)) dut (.CLOCK_I(clk),
    .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SOCK_I(sock), .SOCK_ACCESS_I(sacc), .SUSPEND_I(susp), .CLKRUN_STOP_I(stop),
    .CLK_PIN_I(pin_i), .CLK_PIN_O(pin_o), .CLK_PIN_OE_O(pin_oe), .SOCK_TIMING_CLK_O(tclk),
    .SPEAKER_OUT_O(spk), .MULTIFUNCTION_PIN_O(mf), .MULTIFUNCTION_PIN_OE_O(mf_oe));
  sasl_sock_model sock_mdl (.clk_i(clk), .cfg_i(cfg), .acc_i(acc), .pin_o_i(pin_o),
    .pin_oe_i(pin_oe), .sock_o(sock), .access_o(sacc), .pin_o(pin_i));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // indicator time seen on terminals 3 and 4
  always @(negedge clk) begin
    hi[0] += (mf[3] === 1'h1);
    hi[1] += (mf[4] === 1'h1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk(rdata & m, x);
  endtask
  task automatic pulse(input logic [1:0] s);
    @(posedge clk);
    acc <= s;
    @(posedge clk);
    acc <= 2'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // generous bound, the sequence needs about 400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    {nrst, wr, rd, susp, stop, acc, cfg, addr, wdata} = '0;
    hi = '{0, 0};
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    rd_chk(SYS_CTRL_OFS, '1, 32'h0);
    chk(pin_oe, 1'h0);
    wr_reg(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, '1, 32'h0);
    wr_reg(MF_ROUTE_OFS, 32'h4000_0004);
    foreach (pmv[i]) begin
      wr_reg(FUNC_PM_OFS, {26'h0, pmv[i]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      e = pmv[i][1:0] == PM_STATE_D3 && pmv[i][3:2] == PM_STATE_D3 && |pmv[i][5:4];
      chk({mf_oe[7], mf_oe[0], mf[7]}, {2'h2, !e});
      rd_chk(AUX_STAT_OFS, 32'h1, {31'h0, e});
    end
    wr_reg(SYS_CTRL_OFS, 32'h1 << OSC_EN_BIT);
    repeat (HALF * 2 + 2) @(negedge clk);
    chk(pin_oe, 1'h1);
    n = 0;
    prev = pin_o;
    repeat (HALF * 8) begin
      @(negedge clk);
      n += (pin_o !== prev);
      prev = pin_o;
    end
    chk(n, 8);
    chk(tclk, pin_o);
    wr_reg(SYS_CTRL_OFS, 32'h0);
    repeat (3) @(negedge clk);
    chk({pin_oe, pin_o}, 2'h0);
    for (int v = 0; v < 64; v++) begin
      @(posedge clk);
      cfg <= v[5:0];
      repeat (2) @(negedge clk);
      chk(spk, ^(v[1:0] & (v[3:2] | v[5:4])));
    end
    wr_reg(MF_ROUTE_OFS, 32'h0006_5000);
    // pin enables are registered from the routing register one cycle after the write lands
    repeat (2) @(negedge clk);
    chk(mf_oe[5:3], 3'h3);
    // case 1 restarts the hold with a second access 11 cycles on
    for (int k = 0; k < 3; k++) begin
      hi = '{0, 0};
      pulse(k == 2 ? 2'h2 : 2'h1);
      if (k == 1) begin
        repeat (9) @(posedge clk);
        pulse(2'h1);
      end
      repeat (HOLD * 2) @(posedge clk);
      chk(hi[k / 2], HOLD + (k == 1 ? 11 : 0));
      chk(hi[1 - k / 2], 0);
    end
    for (int c = 0; c < 2; c++) begin
      pulse(2'h2);
      rd_chk(AUX_STAT_OFS, 32'h6, 32'h4);
      @(posedge clk);
      {stop, susp} <= 2'h1 << c;
      repeat (3) @(negedge clk);
      chk(mf[4], 1'h0);
      pulse(2'h2);
      rd_chk(AUX_STAT_OFS, 32'h6, 32'h0);
      @(posedge clk);
      {stop, susp} <= 2'h0;
      repeat (3) @(negedge clk);
      chk(mf[4], 1'h0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
